// [metering_mode_chk.sv]
// Purpose: Port assertions for metering_mode_config.
// Assumes: Only the top ports are visible.
// Notes: Bound to every instance at the foot.
`timescale 1ns/1ps
module metering_mode_chk
   import metering_mode_pkg::*;
(
   input wire logic clock_in,
   input wire logic sys_rst_in,
   input wire logic clk_en_in,
   input wire metering_mode_pkg::reg_req_type req_in,
   input wire metering_mode_pkg::phase_samples_type samples_in,
   input wire logic signed [15:0] line_var_in,
   input wire logic [7:0] rd_data_out,
   input wire logic rd_valid_out,
   input wire logic signed [15:0] wave_sample_out,
   input wire logic wave_strobe_out,
   input wire logic signed [33:0] total_power_out,
   input wire logic signed [33:0] line_power_out,
   input wire logic line_reactive_route_out,
   input wire logic [2:0] neg_power_out
);
   wire logic [2:0] neg_vec;
   // A zero factor never counts as negative power
   function automatic logic ng(logic signed [15:0] v, logic signed [15:0] i);
      return (v[15] ^ i[15]) && v != 0 && i != 0;
   endfunction
   assign neg_vec = {ng(samples_in.vc, samples_in.ic),
      ng(samples_in.vb, samples_in.ib), ng(samples_in.va, samples_in.ia)};
   default clocking @(posedge clock_in); endclocking
   default disable iff (sys_rst_in);
   sequence s_rd;
      clk_en_in && req_in.rd;
   endsequence
   // Route flag may lag its register, so it must hold on two edges
   sequence s_route;
      clk_en_in && line_reactive_route_out ##1 line_reactive_route_out;
   endsequence
   property p_rd_valid;
      s_rd |=> rd_valid_out;
   endproperty
   a_rd_valid: assert property (p_rd_valid) else $error("no read valid");
   // A frozen cycle holds the last answer, so only enabled edges count
   property p_rd_cause;
      $past(clk_en_in) |-> rd_valid_out == $past(req_in.rd);
   endproperty
   a_rd_cause: assert property (p_rd_cause) else $error("stray valid");
   property p_unmapped;
      clk_en_in && req_in.rd && req_in.addr != waveform_mode_addr &&
         req_in.addr != watt_mode_addr |=> rd_data_out == 8'h00;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read");
   property p_gap;
      wave_strobe_out && clk_en_in |=> !wave_strobe_out [*8];
   endproperty
   a_gap: assert property (p_gap) else $error("strobe too soon");
   property p_wave_hold;
      !wave_strobe_out |-> $stable(wave_sample_out);
   endproperty
   a_wave_hold: assert property (p_wave_hold) else $error("wave moved");
   property p_route;
      s_route |-> line_power_out == 34'($past(line_var_in));
   endproperty
   a_route: assert property (p_route) else $error("route wrong");
   property p_neg;
      clk_en_in |=> (neg_power_out & ~$past(neg_vec)) == 3'b000;
   endproperty
   a_neg: assert property (p_neg) else $error("false negative flag");
   property p_zero;
      clk_en_in && samples_in == '0 |=> total_power_out == 34'h0;
   endproperty
   a_zero: assert property (p_zero) else $error("power not zero");
endmodule // metering_mode_chk
bind metering_mode_config metering_mode_chk chk (.clock_in, .sys_rst_in,
   .clk_en_in, .req_in, .samples_in, .line_var_in, .rd_data_out,
   .rd_valid_out, .wave_sample_out, .wave_strobe_out, .total_power_out,
   .line_power_out, .line_reactive_route_out, .neg_power_out);

// [metering_mode_config.sv]
// Purpose: Waveform and watt mode registers and the logic they steer.
// Assumes: Register requests arrive decoded from the serial port, one
//          cycle each; samples are synchronous to clock_in.
// Notes: The energy accumulators live elsewhere; this block hands them
//        gated power terms and routing choices.
`timescale 1ns/1ps
module metering_mode_config
   import metering_mode_pkg::*;
(
   input wire logic clock_in,
   input wire logic sys_rst_in,
   input wire logic clk_en_in,
   input wire metering_mode_pkg::reg_req_type req_in,
   input wire metering_mode_pkg::phase_samples_type samples_in,
   input wire logic signed [15:0] line_var_in,
   output logic [7:0] rd_data_out,
   output logic rd_valid_out,
   output logic signed [15:0] wave_sample_out,
   output logic wave_strobe_out,
   output logic signed [33:0] total_power_out,
   output logic signed [33:0] line_power_out,
   output logic line_reactive_route_out,
   output logic [2:0] neg_power_out
);
   import metering_mode_pkg::*;

   localparam int pw = 33;
   // Register images and the fields decoded from them
   logic [7:0] waveform_mode_reg;
   logic [7:0] watt_mode_reg;
   wave_source_type wave_source_select;
   logic [1:0] wave_rate_select;
   logic line_reactive_route;
   logic [2:0] line_watt_term_enable;
   logic [2:0] watt_term_enable;
   watt_formula_type watt_formula_select;

   // Host request path
   logic wr_wave_hit;
   logic wr_watt_hit;
   logic [7:0] next_waveform_mode;
   logic [7:0] next_watt_mode;
   logic [7:0] next_rd_data;

   // Waveform path
   logic signed [15:0] next_wave;
   logic rate_tick;

   // Power path
   logic signed [15:0] volt [3];
   logic signed [15:0] curr [3];
   logic signed [16:0] ia_ib;
   logic signed [16:0] ic_ib;
   logic signed [pw-1:0] term [3];
   logic signed [pw-1:0] phase_pwr [3];
   logic signed [pw-1:0] tot_gated [3];
   logic signed [pw-1:0] line_gated [3];
   logic signed [33:0] next_total;
   logic signed [33:0] line_formula;
   logic signed [33:0] next_line;
   logic [2:0] next_neg;

   ////////////////////////////////////////////////////////////////////
   // Register decode and field extraction
   assign wr_wave_hit = req_in.wr && (req_in.addr == waveform_mode_addr);
   assign wr_watt_hit = req_in.wr && (req_in.addr == watt_mode_addr);
   assign wave_source_select =
      wave_source_type'(waveform_mode_reg[wave_src_lsb +: 3]);
   assign wave_rate_select = waveform_mode_reg[wave_rate_lsb +: 2];
   assign line_reactive_route = waveform_mode_reg[line_var_bit];
   assign line_watt_term_enable = watt_mode_reg[line_term_lsb +: 3];
   assign watt_term_enable = watt_mode_reg[term_lsb +: 3];
   assign watt_formula_select =
      watt_formula_type'(watt_mode_reg[formula_lsb +: 2]);
   // Unmapped addresses read as zero
   assign next_rd_data =
      (req_in.addr == waveform_mode_addr) ? waveform_mode_reg :
      (req_in.addr == watt_mode_addr) ? watt_mode_reg : 8'h00;
   // A write lands at its edge, so a read in that cycle sees the old value
   assign next_waveform_mode =
      wr_wave_hit ? req_in.data : waveform_mode_reg;
   assign next_watt_mode = wr_watt_hit ? req_in.data : watt_mode_reg;

   // Clock enable low freezes registers and outputs alike; a request
   // offered during a freeze is dropped, not held for later
   always_ff @(posedge clock_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         waveform_mode_reg <= waveform_mode_reset;
         watt_mode_reg <= watt_mode_reset;
         rd_data_out <= 8'h00;
         rd_valid_out <= 1'b0;
      end else if (clk_en_in) begin
         waveform_mode_reg <= next_waveform_mode;
         watt_mode_reg <= next_watt_mode;
         rd_valid_out <= req_in.rd;
         if (req_in.rd) rd_data_out <= next_rd_data;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Waveform sample path
   // The divider runs whatever the source, so a source change shows at
   // the next tick without restarting the sample period
   wave_rate_divider u_rate (
      .clock_in(clock_in),
      .sys_rst_in(sys_rst_in),
      .clk_en_in(clk_en_in),
      .rate_in(wave_rate_select),
      .strobe_out(rate_tick)
   );

   // Reserved sources give zero rather than an arbitrary channel
   always_comb begin
      case (wave_source_select)
         src_volt_a: next_wave = samples_in.va;
         src_volt_b: next_wave = samples_in.vb;
         src_volt_c: next_wave = samples_in.vc;
         src_curr_a: next_wave = samples_in.ia;
         src_curr_b: next_wave = samples_in.ib;
         src_curr_c: next_wave = samples_in.ic;
         default: next_wave = '0;
      endcase
   end

   always_ff @(posedge clock_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         wave_sample_out <= '0;
         wave_strobe_out <= 1'b0;
      end else if (clk_en_in) begin
         wave_strobe_out <= rate_tick;
         if (rate_tick) wave_sample_out <= next_wave;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Active power formula
   assign ia_ib = 17'(samples_in.ia) - 17'(samples_in.ib);
   assign ic_ib = 17'(samples_in.ic) - 17'(samples_in.ib);

   // Phases in order A, B, C so that index g meets enable bit 2-g
   assign volt[0] = samples_in.va;
   assign volt[1] = samples_in.vb;
   assign volt[2] = samples_in.vc;
   assign curr[0] = samples_in.ia;
   assign curr[1] = samples_in.ib;
   assign curr[2] = samples_in.ic;

   always_comb begin
      case (watt_formula_select)
         formula_wye: begin
            term[0] = phase_pwr[0];
            term[1] = phase_pwr[1];
            term[2] = phase_pwr[2];
         end
         // Codes 1 and 2 drop the second term, so its enable gates only the phase B negative flag
         formula_delta_b: begin
            term[0] = pw'(samples_in.va * ia_ib);
            term[1] = '0;
            term[2] = pw'(samples_in.vc * ic_ib);
         end
         formula_delta_c: begin
            term[0] = pw'(samples_in.va * ia_ib);
            term[1] = '0;
            term[2] = phase_pwr[2];
         end
         // Reserved code contributes nothing
         default: begin
            term[0] = '0;
            term[1] = '0;
            term[2] = '0;
         end
      endcase
   end

   // Index 0 is the first term, enabled by the highest bit of each field
   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_term
         // The plain product sign, whatever the formula, marks negative power
         assign phase_pwr[g] = pw'(volt[g] * curr[g]);
         assign tot_gated[g] = watt_term_enable[2-g] ? term[g] : '0;
         assign line_gated[g] =
            line_watt_term_enable[2-g] ? term[g] : '0;
         // Negative flags follow the total enables only, so a phase muted in watt_term_enable never reports
         assign next_neg[g] =
            watt_term_enable[2-g] && phase_pwr[g][pw-1];
      end
   endgenerate

   // Sums are one bit wider than a term so three full-scale terms fit
   assign next_total = 34'(tot_gated[0]) + 34'(tot_gated[1])
      + 34'(tot_gated[2]);
   assign line_formula = 34'(line_gated[0]) + 34'(line_gated[1])
      + 34'(line_gated[2]);
   // Line energy takes reactive power instead when routed
   assign next_line = line_reactive_route ? 34'(line_var_in)
      : line_formula;

   ////////////////////////////////////////////////////////////////////
   // Power output registers
   always_ff @(posedge clock_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         total_power_out <= '0;
         line_power_out <= '0;
         line_reactive_route_out <= 1'b0;
         neg_power_out <= 3'h0;
      end else if (clk_en_in) begin
         total_power_out <= next_total;
         line_power_out <= next_line;
         line_reactive_route_out <= line_reactive_route;
         neg_power_out <= next_neg;
      end
   end
endmodule // metering_mode_config

// [metering_mode_pkg.sv]
// Purpose: Shared constants and types for the metering mode configuration.
// Assumes: Registers are 8 bits wide at fixed serial-port offsets.
// Notes: Field positions and reset values are named here only.
package metering_mode_pkg;
   localparam logic [7:0] waveform_mode_addr = 8'h0c;
   localparam logic [7:0] watt_mode_addr = 8'h0d;
   localparam logic [7:0] waveform_mode_reset = 8'h00;
   localparam logic [7:0] watt_mode_reset = 8'h3f;
   localparam int wave_src_lsb = 0;
   localparam int wave_rate_lsb = 3;
   localparam int line_var_bit = 5;
   localparam int line_term_lsb = 0;
   localparam int term_lsb = 3;
   localparam int formula_lsb = 6;
   localparam int pre_divide = 3;
   localparam int base_divide = 128;
   localparam int neg_power_lsb = 12;

   typedef enum logic [2:0] {
      src_volt_a, src_volt_b, src_volt_c,
      src_curr_a, src_curr_b, src_curr_c,
      src_rsvd_6, src_rsvd_7
   } wave_source_type;

   typedef enum logic [1:0] {
      formula_wye, formula_delta_b, formula_delta_c, formula_rsvd
   } watt_formula_type;

   // One phase sample set, voltages and currents
   typedef struct packed {
      logic signed [15:0] va;
      logic signed [15:0] vb;
      logic signed [15:0] vc;
      logic signed [15:0] ia;
      logic signed [15:0] ib;
      logic signed [15:0] ic;
   } phase_samples_type;

   // Register bus request on the serial-port side
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] data;
   } reg_req_type;
endpackage

// [test_metering_mode_config.sv]
// Purpose: Self-checking bench for metering_mode_config.
// Assumes: 12-bit samples, so no power sum overflows.
// Notes: Power expectations come from the bench function pw; the others are computed inline.
`timescale 1ns/1ps
module test_metering_mode_config;
   import metering_mode_pkg::*;
   logic clock_in, sys_rst_in, clk_en_in, rd_valid_out, wave_strobe_out;
   logic line_reactive_route_out;
   reg_req_type req_in;
   phase_samples_type samples_in, s;
   logic signed [15:0] line_var_in, wave_sample_out;
   logic signed [33:0] total_power_out, line_power_out;
   logic [7:0] rd_data_out, wm, wv;
   logic [2:0] neg_power_out;
   int err_count, compares, n;
   metering_mode_config dut (.clock_in, .sys_rst_in, .clk_en_in, .req_in,
      .samples_in, .line_var_in, .rd_data_out, .rd_valid_out,
      .wave_sample_out, .wave_strobe_out, .total_power_out,
      .line_power_out, .line_reactive_route_out, .neg_power_out);
   initial begin
      clock_in = 0;
      forever #12.5 clock_in = ~clock_in;
   end
   task automatic chk_reg(string nm, logic [7:0] e, logic [7:0] g);
      compares++;
      if (g !== e) begin
         err_count++;
         $display("mismatch %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic chk_pwr(string nm, logic [33:0] e, logic [33:0] g);
      compares++;
      if (g !== e) begin
         err_count++;
         $display("mismatch %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic chk_wave(string nm, logic [33:0] e, logic [33:0] g);
      compares++;
      if (g !== e) begin
         err_count++;
         $display("mismatch %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic final_report;
      $display("compares %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic bus(logic r, logic [7:0] a, logic [7:0] d);
      @(posedge clock_in);
      req_in <= {~r, r, a, d};
      @(posedge clock_in);
      req_in <= '0;
      #1;
   endtask
   task automatic rd(logic [7:0] a, logic [7:0] e);
      bus(1, a, 8'h00);
      chk_reg("rd_valid", 8'h01, rd_valid_out);
      chk_reg("rd_data", e, rd_data_out);
   endtask
   task automatic wstb;
      for (n = 1; n < 4000; n++) begin
         @(posedge clock_in);
         #1;
         if (wave_strobe_out === 1'b1) return;
      end
      err_count++;
      $display("mismatch wave_strobe exp 1 got 0");
      final_report;
   endtask
   function automatic logic signed [15:0] rs;
      return 16'($urandom_range(4095)) - 16'sd2048;
   endfunction
   // Enable bit 2 of en is the first term of the formula
   function automatic int pw(phase_samples_type p, logic [1:0] f,
      logic [2:0] en);
      int t1, t2, t3;
      t1 = p.va * (p.ia - (f != 0 ? p.ib : 16'sd0));
      t2 = f == 0 ? p.vb * p.ib : 0;
      t3 = p.vc * (p.ic - (f == 1 ? p.ib : 16'sd0));
      if (f == 3) return 0;
      return (en[2] ? t1 : 0) + (en[1] ? t2 : 0) + (en[0] ? t3 : 0);
   endfunction
   task automatic pchk;
      s = {rs(), rs(), rs(), rs(), rs(), rs()};
      @(posedge clock_in);
      samples_in <= s;
      line_var_in <= rs();
      @(posedge clock_in);
      #1;
      chk_pwr("total", 34'(pw(s, wm[7:6], wm[5:3])), total_power_out);
      chk_pwr("line", wv[5] ? 34'(line_var_in) : 34'(pw(s, wm[7:6], wm[2:0])),
         line_power_out);
      chk_pwr("neg", {s.vc * s.ic < 0 && wm[3], s.vb * s.ib < 0 && wm[4],
         s.va * s.ia < 0 && wm[5]}, neg_power_out);
      chk_reg("route", wv[5], line_reactive_route_out);
   endtask
   initial begin
      sys_rst_in = 1;
      clk_en_in = 1;
      req_in = '0;
      samples_in = '0;
      line_var_in = 0;
      err_count = 0;
      compares = 0;
      void'($urandom(32'h350d8963));
      repeat (8) @(posedge clock_in);
      sys_rst_in <= 0;
      wm = 8'h3f;
      wv = 8'h00;
      rd(8'h0c, 8'h00);
      rd(8'h0d, 8'h3f);
      rd(8'h0e, 8'h00);
      $display("test reset done");
      for (int i = 0; i < 30; i++) begin
         wm = i == 0 ? 8'h00 : i == 1 ? 8'h87 : {2'($urandom_range(2)),
            6'($urandom)};
         wv = {2'b00, 1'($urandom), 5'h00};
         bus(0, 8'h0d, wm);
         bus(0, 8'h0c, wv);
         rd(8'h0d, wm);
         pchk;
         pchk;
      end
      $display("test power done");
      @(posedge clock_in);
      clk_en_in <= 0;
      bus(0, 8'h0d, 8'h00);
      s = {16'sd11, 16'sd22, 16'sd33, -16'sd44, -16'sd55, 16'sd66};
      @(posedge clock_in);
      clk_en_in <= 1;
      samples_in <= s;
      rd(8'h0d, wm);
      for (int k = 0; k < 8; k++) begin
         bus(0, 8'h0c, 8'(k));
         wstb;
         wstb;
         chk_wave("wave", k < 6 ? 34'(signed'(s[95 - 16 * k -: 16])) : 34'h0,
            wave_sample_out);
      end
      for (int r = 0; r < 4; r++) begin
         bus(0, 8'h0c, 8'(r << 3));
         wstb;
         wstb;
         chk_wave("period", 3 * (128 << r), n);
      end
      $display("test wave done");
      final_report;
   end
endmodule // test_metering_mode_config

// [wave_rate_divider.sv]
// Purpose: Generates the waveform sample strobe from the master clock.
// Assumes: Rate code may change at any time; the count is not restarted, and it wraps at the next pre_divide wrap if past the new end.
// Notes: Divides by pre_divide, then by base_divide shifted by the code.
`timescale 1ns/1ps
module wave_rate_divider
   import metering_mode_pkg::*;
(
   input wire logic clock_in,
   input wire logic sys_rst_in,
   input wire logic clk_en_in,
   input wire logic [1:0] rate_in,
   output logic strobe_out
);
   localparam int pre_w = 2;
   localparam int post_w = 10;
   logic [pre_w-1:0] pre_cnt;
   logic [post_w-1:0] post_cnt;
   logic [post_w-1:0] post_last;
   logic pre_wrap;

   ////////////////////////////////////////////////////////////////////
   assign pre_wrap = (pre_cnt == pre_w'(pre_divide - 1));
   assign post_last = post_w'((base_divide << rate_in) - 1);

   always_ff @(posedge clock_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         pre_cnt <= '0;
         post_cnt <= '0;
         strobe_out <= 1'b0;
      end else if (clk_en_in) begin
         pre_cnt <= pre_wrap ? '0 : pre_cnt + 1'b1;
         strobe_out <= 1'b0;
         // Using >= so a shortened rate never strands the count high
         if (pre_wrap) begin
            if (post_cnt >= post_last) begin
               post_cnt <= '0;
               strobe_out <= 1'b1;
            end else begin
               post_cnt <= post_cnt + 1'b1;
            end
         end
      end
   end
endmodule // wave_rate_divider
